// file: rtl/gpio_pkg.sv
// Constants, types and helpers for the double-edge pad interface cell
//
// Summary of operation
// R1: Single-rate input drives data bit 0
// R2: Double-edge: rise sample bit 0, fall bit 1
// R3: Unregistered alternate input toward clock networks; here alt_input is registered, one clk after pad_in
// R4: Pad driven from output data bit 0
// R5: Double-edge: bit 0 on rise, bit 1 on fall
// R6: Drive enable passes directly or registered
// R7: Launch clock times output and enable registers
// R8: Capture clock times input registers independently
// R9: Double-edge registers use both edges, 2-bit data
// R10: Normal alignment moves each bit at its edge
// R11: Resync alignment exchanges both bits on rise
// R12: Resync input holds fall bit half period
// R13: Single-ended differential cells lack double-edge mode
// R14: Enable drives pad for output, else releases
// R15: Each register picks rising or falling edge
// R16: Optional inversion of registered output data
// R17: Enable register stays single-rate in double-edge mode
package gpio_pkg;

  localparam int DATA_W = 2;
  localparam int ADDR_W = 4;
  localparam int BUF_DEPTH = 2;

  // Wishbone register map (byte addresses)
  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;

  // Control register fields, high bits first
  localparam int CFG_W = 10;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // Status register fields
  localparam int ST_PAD = 0;
  localparam int ST_OVF = 1;
  localparam int ST_WORD = 2;
  localparam int ST_VALID = 4;

  typedef struct packed {
    logic out_invert;
    logic oe_fall;
    logic out_fall;
    logic in_fall;
    logic resync;
    logic ddr;
    logic oe_reg;
    logic out_reg;
    logic in_reg;
    logic single_ended;
  } cfg_s;

  typedef struct packed {
    logic fall_bit;
    logic rise_bit;
  } word_s;

  typedef enum {PATH_BYPASS, PATH_SDR, PATH_DDR_NORMAL, PATH_DDR_RESYNC} path_mode_e;

  // Path mode from configuration; single-ended cells never go double-edge
  function automatic path_mode_e path_mode(input logic reg_en, input cfg_s c);
    if (!reg_en) begin
      return PATH_BYPASS;
    end else if (!c.ddr || c.single_ended) begin
      return PATH_SDR;
    end else if (c.resync) begin
      return PATH_DDR_RESYNC;
    end
    return PATH_DDR_NORMAL;
  endfunction

endpackage

// file: rtl/double_edge_mode_word_buffer.sv
// Shift-organised word buffer with valid/ready on both sides
`timescale 1ns/10ps
module double_edge_mode_word_buffer #(
  parameter int WIDTH = gpio_pkg::DATA_W,
  parameter int DEPTH = gpio_pkg::BUF_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  import gpio_pkg::*;

  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_ff[0];

  always_comb begin
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + CW'(1);
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      out_valid <= 1'b0;
      in_ready <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      out_valid <= nxt_cnt != '0;
      in_ready <= nxt_cnt < CW'(DEPTH);
    end
  end

  // Head at entry 0; a pop shifts the rest down
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    logic [WIDTH-1:0] above;
    if (i == DEPTH - 1) begin : g_top
      assign above = mem_ff[i];
    end else begin : g_mid
      assign above = mem_ff[i+1];
    end
    always_ff @(posedge clk) begin
      if (pop) begin
        mem_ff[i] <= (push && cnt_ff == CW'(i + 1)) ? in_data : above;
      end else if (push && cnt_ff == CW'(i)) begin
        mem_ff[i] <= in_data;
      end
    end
  end

endmodule

// file: rtl/gpio_double_edge_mode_pad_interface.sv
// Pad interface cell: input, output and enable paths with double-edge option
//
// Design decisions made here: the placing of the registers and register access over Wishbone.
`timescale 1ns/10ps
module gpio_double_edge_mode_pad_interface (
  input wire logic clk,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [gpio_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Fabric side
  input wire logic pad_capture_clock,
  input wire logic pad_launch_clock,
  input wire logic [gpio_pkg::DATA_W-1:0] core_output_data,
  input wire logic pad_drive_enable,
  output gpio_pkg::word_s core_input_data,
  output logic core_input_valid,
  input wire logic core_input_ready,
  output logic alt_input,
  // Pad
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe_n
);
  import gpio_pkg::*;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [31:0] ctrl_ff;
  logic ovf_ff;
  logic wb_req;
  logic wb_hit;
  logic wr_ctrl;
  logic wr_status;
  cfg_s cfg;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Writes land at the edge where the master samples ack
  assign wb_hit = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;
  assign wr_ctrl = wb_hit && wb_adr_i == CTRL_OFS;
  assign wr_status = wb_hit && wb_adr_i == STATUS_OFS;
  assign cfg = cfg_s'(ctrl_ff[CFG_W-1:0]);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_ff <= CTRL_RST;
    end else if (wr_ctrl) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          ctrl_ff[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
        end
      end
    end
  end

  logic pad_ff;
  word_s last_word_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      wb_dat_o <= 32'h0000_0000;
      if (wb_adr_i == CTRL_OFS) begin
        wb_dat_o <= {{(32 - CFG_W){1'b0}}, ctrl_ff[CFG_W-1:0]};
      end else if (wb_adr_i == STATUS_OFS) begin
        wb_dat_o[ST_PAD] <= pad_ff;
        wb_dat_o[ST_OVF] <= ovf_ff;
        wb_dat_o[ST_WORD +: DATA_W] <= last_word_ff;
        wb_dat_o[ST_VALID] <= core_input_valid;
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock edge detection
  // ----------------------------------------------------------------
  logic cap_prev_ff;
  logic lau_prev_ff;
  logic cap_rise;
  logic cap_fall;
  logic lau_rise;
  logic lau_fall;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cap_prev_ff <= 1'b0;
      lau_prev_ff <= 1'b0;
    end else begin
      cap_prev_ff <= pad_capture_clock;
      lau_prev_ff <= pad_launch_clock;
    end
  end

  assign cap_rise = pad_capture_clock && !cap_prev_ff; // R8
  assign cap_fall = !pad_capture_clock && cap_prev_ff;
  assign lau_rise = pad_launch_clock && !lau_prev_ff; // R7
  assign lau_fall = !pad_launch_clock && lau_prev_ff;

  // ----------------------------------------------------------------
  // Input path
  // ----------------------------------------------------------------
  path_mode_e in_mode;
  path_mode_e out_mode;
  logic in_edge;
  logic fall_hold_ff;
  word_s nxt_word;
  logic nxt_push;
  logic buf_ready;

  assign in_mode = path_mode(cfg.in_reg, cfg);
  assign out_mode = path_mode(cfg.out_reg, cfg);
  assign in_edge = cfg.in_fall ? cap_fall : cap_rise; // R15

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pad_ff <= 1'b0;
      alt_input <= 1'b0;
    end else begin
      pad_ff <= pad_in;
      alt_input <= pad_in; // R3
    end
  end

  always_comb begin
    nxt_word = last_word_ff;
    nxt_push = 1'b0;
    unique case (in_mode)
      PATH_BYPASS: begin
        nxt_word = '{fall_bit: 1'b0, rise_bit: pad_in}; // R1
        nxt_push = pad_in != last_word_ff.rise_bit;
      end
      PATH_SDR: begin
        nxt_word = '{fall_bit: 1'b0, rise_bit: pad_in}; // R1 R13
        nxt_push = in_edge;
      end
      PATH_DDR_NORMAL: begin
        if (cap_rise) begin
          nxt_word.rise_bit = pad_in; // R2 R10
          nxt_push = 1'b1;
        end else if (cap_fall) begin
          nxt_word.fall_bit = pad_in; // R2 R9 R10
          nxt_push = 1'b1;
        end
      end
      PATH_DDR_RESYNC: begin
        nxt_word = '{fall_bit: fall_hold_ff, rise_bit: pad_in}; // R11 R12
        nxt_push = cap_rise;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fall_hold_ff <= 1'b0;
    end else if (cap_fall) begin
      fall_hold_ff <= pad_in; // R12
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      last_word_ff <= '0;
    end else if (nxt_push) begin
      last_word_ff <= nxt_word;
    end
  end

  // Overflow is sticky; a new loss wins over a software clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ovf_ff <= 1'b0;
    end else if (nxt_push && !buf_ready) begin
      ovf_ff <= 1'b1;
    end else if (wr_status && wb_sel_i[0] && wb_dat_i[ST_OVF]) begin
      ovf_ff <= 1'b0;
    end
  end

  double_edge_mode_word_buffer #(
    .WIDTH(DATA_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .in_data(nxt_word),
    .in_valid(nxt_push),
    .in_ready(buf_ready),
    .out_data(core_input_data),
    .out_valid(core_input_valid),
    .out_ready(core_input_ready)
  );

  // ----------------------------------------------------------------
  // Output and enable paths
  // ----------------------------------------------------------------
  logic out_edge;
  logic oe_edge;
  logic fall_out_ff;
  logic out_q_ff;

  assign out_edge = cfg.out_fall ? lau_fall : lau_rise; // R15
  assign oe_edge = cfg.oe_fall ? lau_fall : lau_rise; // R15 R17

  // Resync output: both bits taken on rise, fall bit held for the fall
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fall_out_ff <= 1'b0;
    end else if (lau_rise) begin
      fall_out_ff <= core_output_data[1]; // R11
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_q_ff <= 1'b0;
    end else begin
      unique case (out_mode)
        PATH_BYPASS: out_q_ff <= core_output_data[0]; // R4
        PATH_SDR: begin
          if (out_edge) begin
            out_q_ff <= core_output_data[0]; // R4 R13
          end
        end
        PATH_DDR_NORMAL: begin
          if (lau_rise) begin
            out_q_ff <= core_output_data[0]; // R5 R9
          end else if (lau_fall) begin
            out_q_ff <= core_output_data[1]; // R5 R10
          end
        end
        PATH_DDR_RESYNC: begin
          if (lau_rise) begin
            out_q_ff <= core_output_data[0]; // R5
          end else if (lau_fall) begin
            out_q_ff <= fall_out_ff; // R11
          end
        end
      endcase
    end
  end

  logic invert;
  assign invert = cfg.out_invert && out_mode != PATH_BYPASS; // R16

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pad_out <= 1'b0;
    end else begin
      pad_out <= invert ? !out_q_ff : out_q_ff; // R16
    end
  end

  // Registered enable stays single-rate on the chosen launch edge; with oe_reg clear it follows pad_drive_enable every clk
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pad_oe_n <= 1'b1;
    end else if (!cfg.oe_reg || oe_edge) begin
      pad_oe_n <= !pad_drive_enable; // R6 R14 R17
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence rise_seen_s;
    in_mode == PATH_DDR_NORMAL && cap_rise && buf_ready;
  endsequence

  sequence fall_then_rise_s;
    (in_mode == PATH_DDR_RESYNC && cap_fall) ##[1:1000]
      (in_mode == PATH_DDR_RESYNC && cap_rise);
  endsequence

  sdr_in_bit0_a: assert property (in_mode == PATH_SDR && in_edge |=> // R1
    last_word_ff.rise_bit == $past(pad_in))
    else $error("single-rate input not on bit 0");
  ddr_rise_bit_a: assert property (rise_seen_s |=> // R2
    last_word_ff.rise_bit == $past(pad_in) && core_input_valid)
    else $error("rising sample missing from bit 0");
  resync_hold_a: assert property (fall_then_rise_s |=> // R12
    last_word_ff.fall_bit == $past(fall_hold_ff))
    else $error("resync fall bit not held to rise");
  resync_rise_only_a: assert property (in_mode == PATH_DDR_RESYNC && // R11
    $changed(last_word_ff) |-> $past(cap_rise))
    else $error("resync word changed off rising edge");
  alt_follows_pad_a: assert property (##1 alt_input == $past(pad_in)) // R3
    else $error("alternate input does not follow pad");
  ddr_out_fall_a: assert property (out_mode == PATH_DDR_NORMAL && lau_fall // R5
    |=> ##1 pad_out == ($past(core_output_data[1], 2) ^ invert))
    else $error("fall output bit not launched");
  sdr_out_hold_a: assert property (out_mode == PATH_SDR && !out_edge && // R15
    $stable(cfg) |=> $stable(out_q_ff))
    else $error("output register moved off its edge");
  oe_single_rate_a: assert property (cfg.oe_reg && !oe_edge && $stable(cfg) // R17
    |=> $stable(pad_oe_n))
    else $error("enable register moved off its edge");
  oe_direct_a: assert property (!cfg.oe_reg |=> pad_oe_n == !$past(pad_drive_enable)) // R14
    else $error("direct enable not passed to driver");
  single_no_ddr_a: assert property (cfg.single_ended && nxt_push |=> // R13
    last_word_ff.fall_bit == 1'b0)
    else $error("double-edge mode on single-ended cell");

endmodule

// file: verif/fabric_model.sv
// Fabric-side model: capture/launch clocks, output data, input word sink
`timescale 1ns/10ps
module fabric_model (
  input wire logic clk,
  output logic pad_capture_clock,
  output logic pad_launch_clock,
  output logic [1:0] core_output_data,
  output logic pad_drive_enable,
  input wire gpio_pkg::word_s core_input_data,
  input wire logic core_input_valid,
  output logic core_input_ready
);
  import gpio_pkg::*;
  logic [1:0] got_q[$];
  logic stall;
  initial begin
    pad_capture_clock = 1'b0;
    pad_launch_clock = 1'b0;
    core_output_data = 2'h0;
    pad_drive_enable = 1'b0;
    core_input_ready = 1'b0;
    stall = 1'b0;
  end
  // Sink takes the head word unless stalled
  always @(posedge clk) begin
    core_input_ready <= !stall;
    if (core_input_valid === 1'b1 && core_input_ready) begin
      got_q.push_back(core_input_data);
    end
  end
  // Clocks move only on request; each capture level lasts at least 5 clk, each launch level at least 6
  task automatic cap_edge();
    @(posedge clk) pad_capture_clock <= !pad_capture_clock;
    repeat (4) @(posedge clk);
  endtask
  task automatic launch_edge(input logic [1:0] d, input logic oe);
    @(posedge clk) begin
      core_output_data <= d;
      pad_drive_enable <= oe;
    end
    @(posedge clk) pad_launch_clock <= !pad_launch_clock;
    repeat (4) @(posedge clk);
  endtask
endmodule

// file: verif/gpio_double_edge_mode_pad_interface_bench.sv
// Self-checking bench for the double-edge pad interface cell
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module gpio_double_edge_mode_pad_interface_bench;
  import gpio_pkg::*;
  logic clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, pad_ext, pad_out, pad_oe_n;
  logic [ADDR_W-1:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic cap_clk, lau_clk, drv_en, in_valid, in_ready, alt_input;
  logic [1:0] out_data;
  word_s in_data;
  int bad_count = 0;
  int n_checks = 0;
  // Pad wire: cell drives when enable low, else the outside world
  wire logic pad_wire = !pad_oe_n ? pad_out : pad_ext;
  gpio_double_edge_mode_pad_interface i_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pad_capture_clock(cap_clk), .pad_launch_clock(lau_clk), .core_output_data(out_data),
    .pad_drive_enable(drv_en), .core_input_data(in_data), .core_input_valid(in_valid),
    .core_input_ready(in_ready), .alt_input(alt_input), .pad_in(pad_wire),
    .pad_out(pad_out), .pad_oe_n(pad_oe_n));
  fabric_model i_fab (.clk(clk), .pad_capture_clock(cap_clk), .pad_launch_clock(lau_clk),
    .core_output_data(out_data), .pad_drive_enable(drv_en), .core_input_data(in_data),
    .core_input_valid(in_valid), .core_input_ready(in_ready));
  // ----------------------------------------
  // Bus and stimulus helpers
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk) begin
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
    end
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      bad_count++;
      test_done();
    end
  endtask
  task automatic cap(input logic v);
    @(posedge clk) pad_ext <= v;
    i_fab.cap_edge();
  endtask
  task automatic lstep(input logic [1:0] d, input logic oe, input logic eo, input logic en);
    i_fab.launch_edge(d, oe);
    `CHK("pad_out", eo, pad_out)
    `CHK("pad_oe_n", en, pad_oe_n)
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    `CHK("oe_n rst", 1'b1, pad_oe_n)
    wb(1'b0, CTRL_OFS, 32'h0);
    `CHK("ctrl rst", CTRL_RST, rd)
    wb(1'b1, CTRL_OFS, 32'h0000_020C);
    wb(1'b0, CTRL_OFS, 32'h0);
    `CHK("ctrl rb", 32'h0000_020C, rd)
    wb(1'b1, 4'h8, 32'hFFFF_FFFF);
    wb(1'b0, 4'h8, 32'h0);
    `CHK("unmapped", 32'h0000_0000, rd)
    wb(1'b1, CTRL_OFS, 32'h0);
    pad_ext <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("alt", 1'b1, alt_input)
    $display("test regs done");
  endtask
  task automatic t_input();
    wb(1'b1, CTRL_OFS, 32'h0000_0002);
    i_fab.got_q.delete();
    cap(1'b1); cap(1'b0);
    `CHK("sdr n", 1, i_fab.got_q.size())
    `CHK("sdr w", 2'b01, i_fab.got_q[0])
    wb(1'b1, CTRL_OFS, 32'h0000_0042);
    i_fab.got_q.delete();
    cap(1'b0); cap(1'b1);
    `CHK("fall n", 1, i_fab.got_q.size())
    `CHK("fall w", 2'b01, i_fab.got_q[0])
    wb(1'b1, CTRL_OFS, 32'h0000_0012);
    i_fab.got_q.delete();
    cap(1'b1); cap(1'b0); cap(1'b0); cap(1'b1);
    `CHK("ddr n", 4, i_fab.got_q.size())
    `CHK("ddr w1", 2'b01, i_fab.got_q[1])
    `CHK("ddr w3", 2'b10, i_fab.got_q[3])
    wb(1'b1, CTRL_OFS, 32'h0000_0032);
    i_fab.got_q.delete();
    cap(1'b0); cap(1'b1); cap(1'b0); cap(1'b0);
    `CHK("rsy n", 2, i_fab.got_q.size())
    `CHK("rsy w", 2'b10, i_fab.got_q[1])
    wb(1'b1, CTRL_OFS, 32'h0000_0013);
    i_fab.got_q.delete();
    cap(1'b1);
    cap(1'b0);
    `CHK("se n", 1, i_fab.got_q.size())
    `CHK("se w", 2'b01, i_fab.got_q[0])
    $display("test input done");
  endtask
  task automatic t_overflow();
    wb(1'b1, CTRL_OFS, 32'h0000_0012);
    i_fab.got_q.delete();
    i_fab.stall = 1'b1;
    cap(1'b1); cap(1'b0); cap(1'b1); cap(1'b0);
    wb(1'b0, STATUS_OFS, 32'h0);
    `CHK("ovf", 2'b11, {rd[ST_VALID], rd[ST_OVF]})
    wb(1'b1, STATUS_OFS, 32'h0000_0002);
    wb(1'b0, STATUS_OFS, 32'h0);
    `CHK("ovf clr", 1'b0, rd[ST_OVF])
    i_fab.stall = 1'b0;
    repeat (8) @(posedge clk);
    `CHK("drain", 2, i_fab.got_q.size())
    $display("test overflow done");
  endtask
  task automatic t_output();
    wb(1'b1, CTRL_OFS, 32'h0);
    lstep(2'b01, 1'b1, 1'b1, 1'b0);
    lstep(2'b10, 1'b0, 1'b0, 1'b1);
    wb(1'b1, CTRL_OFS, 32'h0000_020C);
    lstep(2'b01, 1'b1, 1'b0, 1'b0);
    lstep(2'b00, 1'b0, 1'b0, 1'b0);
    lstep(2'b00, 1'b0, 1'b1, 1'b1);
    lstep(2'b01, 1'b1, 1'b1, 1'b1);
    wb(1'b1, CTRL_OFS, 32'h0000_0014);
    lstep(2'b10, 1'b0, 1'b0, 1'b1);
    lstep(2'b10, 1'b0, 1'b1, 1'b1);
    wb(1'b1, CTRL_OFS, 32'h0000_0015);
    lstep(2'b10, 1'b0, 1'b0, 1'b1);
    lstep(2'b10, 1'b0, 1'b0, 1'b1);
    wb(1'b1, CTRL_OFS, 32'h0000_0034);
    lstep(2'b10, 1'b0, 1'b0, 1'b1);
    lstep(2'b00, 1'b0, 1'b1, 1'b1);
    wb(1'b1, CTRL_OFS, 32'h0000_018C);
    lstep(2'b00, 1'b1, 1'b1, 1'b1);
    lstep(2'b00, 1'b1, 1'b0, 1'b0);
    $display("test output done");
  endtask
  // ----------------------------------------
  // Clock, reset, sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = !clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    test_done();
  end
  initial begin
    rst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    pad_ext = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_input();
    t_overflow();
    t_output();
    test_done();
  end
endmodule
